// *** src/csi_buffer.sv ***
// Clocked serial interface: data buffers, single transfer control and Wishbone slave
`timescale 1ns/1ps
module csi_buffer #(
    parameter int HALF_CYC = csi_pkg::SCK_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    output logic serial_out_pin,
    input wire logic serial_in_pin,
    output logic completion_interrupt
);
    import csi_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    mode_s mode; // Serial mode register
    logic slave_mode; // 1 = clock from the peer
    logic [15:0] rx_buf; // Receive buffer, shared by all its views
    logic [15:0] tx_buf; // Transmit buffer, word and byte views
    logic [15:0] init_buf; // Initial transmit data for repeat mode
    logic [15:0] shifter; // Serial shift register
    logic [4:0] bit_cnt; // Bits completed in this transfer
    logic [7:0] div_cnt; // Master clock divider
    logic [2:0] sck_sync; // Synchroniser plus edge history
    logic [1:0] si_sync; // Data-in synchroniser
    logic sck_int; // Master serial clock level

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic access; // First cycle of a bus request
    logic word_ok; // Lanes form one whole 16-bit access
    logic byte_ok; // Lanes include the low byte only
    logic rd_rx; // Starting-capable receive buffer read
    logic wr_tx; // Transmit buffer write
    logic start; // Transfer begins this cycle
    logic rise; // Serial clock rising edge seen
    logic fall; // Serial clock falling edge seen
    logic done; // Last bit sampled
    logic [4:0] last_bit; // Bit count of the active length
    logic [15:0] next_shift; // Shifter after one sampled bit
    logic out_bit; // Bit to present on the data line

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign word_ok = (wb_sel_i == SEL_WORD16);
    assign byte_ok = (wb_sel_i == SEL_BYTE0);
    assign last_bit = mode.ccl ? BITS_LONG : BITS_SHORT;

    // width of start access follows length
    assign rd_rx = access && !wb_we_i && ((wb_adr_i == OFF_RX_WORD && word_ok && mode.ccl)
                   || (wb_adr_i == OFF_RX_BYTE && byte_ok && !mode.ccl));
    assign wr_tx = access && wb_we_i && ((wb_adr_i == OFF_TX_WORD && word_ok && mode.ccl)
                   || (wb_adr_i == OFF_TX_BYTE && byte_ok && !mode.ccl));

    assign start = mode.enable && !mode.status && (mode.trmd ? wr_tx : rd_rx);

    // Edges come from the divider in master mode, the synchronised pin otherwise
    assign rise = mode.status && (slave_mode ? (sck_sync[1] && !sck_sync[2])
                                             : (div_cnt == 8'd0 && !sck_int));
    assign fall = mode.status && (slave_mode ? (!sck_sync[1] && sck_sync[2])
                                             : (div_cnt == 8'd0 && sck_int));

    // stop after the active bit count
    assign done = rise && (bit_cnt == last_bit - 5'd1);

    // shift toward the first-bit end, enter at the far end
    always_comb begin
        next_shift = shifter;
        if (!mode.dir) begin
            next_shift = {shifter[14:0], si_sync[1]};
        end else if (mode.ccl) begin
            next_shift = {si_sync[1], shifter[15:1]};
        end else begin
            next_shift = {shifter[15:8], si_sync[1], shifter[7:1]};
        end
    end

    // First bit out sits at the top of the active width, or bit 0 for LSB first
    always_comb begin
        if (mode.dir) begin
            out_bit = shifter[0];
        end else if (mode.ccl) begin
            out_bit = shifter[15];
        end else begin
            out_bit = shifter[7];
        end
    end

    // ----------------------------------------
    // Wishbone acknowledge and read data
    // ----------------------------------------

    // Single-wait answer; every address, mapped or not, is acknowledged
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Read mux; a view read at the wrong width returns zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (access && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            unique case (wb_adr_i)
                OFF_MODE: wb_dat_o[7:0] <= {mode[7:2], 1'b0, mode.status};
                OFF_CLOCK: wb_dat_o[0] <= slave_mode;
                // word views only as whole 16 bits
                // mirror read shares data, no start
                OFF_RX_WORD, OFF_MIRROR_WORD: begin
                    if (word_ok) wb_dat_o[15:0] <= rx_buf;
                end
                // byte view is low byte of word
                OFF_RX_BYTE, OFF_MIRROR_BYTE: begin
                    if (byte_ok) wb_dat_o[7:0] <= rx_buf[7:0];
                end
                // transmit and initial words read back
                OFF_TX_WORD: begin
                    if (word_ok) wb_dat_o[15:0] <= tx_buf;
                end
                OFF_TX_BYTE: begin
                    if (byte_ok) wb_dat_o[7:0] <= tx_buf[7:0];
                end
                OFF_INIT_WORD: begin
                    if (word_ok) wb_dat_o[15:0] <= init_buf;
                end
                OFF_INIT_BYTE: begin
                    if (byte_ok) wb_dat_o[7:0] <= init_buf[7:0];
                end
                // shifter view reads without side effect
                OFF_SHIFT_WORD: begin
                    if (word_ok) wb_dat_o[15:0] <= shifter;
                end
                OFF_SHIFT_BYTE: begin
                    if (byte_ok) wb_dat_o[7:0] <= shifter[7:0];
                end
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------

    // Mode register; the status flag is hardware owned
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= mode_s'(MODE_RESET);
        end else begin
            if (access && wb_we_i && wb_adr_i == OFF_MODE && wb_sel_i[0]) begin
                mode.enable <= wb_dat_i[7];
                mode.trmd <= wb_dat_i[6];
                mode.ccl <= wb_dat_i[5];
                mode.dir <= wb_dat_i[4];
                mode.delay <= wb_dat_i[3];
                mode.auto_sel <= wb_dat_i[2];
            end
            mode.spare <= 1'b0;
            // disable drops the status flag at once
            if (!mode.enable || done) begin
                mode.status <= 1'b0;
            end else if (start) begin
                // status high from start to end
                mode.status <= 1'b1;
            end
        end
    end

    // Clock source select, only meaningful while disabled
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_mode <= 1'b0;
        end else if (access && wb_we_i && wb_adr_i == OFF_CLOCK && wb_sel_i[0]) begin
            slave_mode <= wb_dat_i[0];
        end
    end

    // Transmit and initial buffers; these survive a disable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf <= DATA_RESET;
            init_buf <= DATA_RESET;
        end else if (access && wb_we_i) begin
            // word writes need both low lanes
            if (wb_adr_i == OFF_TX_WORD && word_ok) tx_buf <= wb_dat_i[15:0];
            if (wb_adr_i == OFF_TX_BYTE && byte_ok) tx_buf[7:0] <= wb_dat_i[7:0];
            if (wb_adr_i == OFF_INIT_WORD && word_ok) init_buf <= wb_dat_i[15:0];
            if (wb_adr_i == OFF_INIT_BYTE && byte_ok) init_buf[7:0] <= wb_dat_i[7:0];
        end
    end

    // ----------------------------------------
    // Serial clock: synchroniser and master divider
    // ----------------------------------------

    // Pin inputs pass two flops; stage 2 feeds the edge history stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sck_sync <= 3'b111;
            si_sync <= 2'b00;
        end else begin
            sck_sync <= {sck_sync[1:0], serial_clock_pin_i};
            si_sync <= {si_sync[0], serial_in_pin};
        end
    end

    // Divider runs only during a transfer so the first half period is full
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'd0;
            sck_int <= 1'b1;
        end else if (!mode.status || slave_mode) begin
            div_cnt <= 8'(HALF_CYC - 1);
            sck_int <= 1'b1;
        end else if (div_cnt == 8'd0) begin
            div_cnt <= 8'(HALF_CYC - 1);
            sck_int <= !sck_int;
        end else begin
            div_cnt <= div_cnt - 8'd1;
        end
    end

    // ----------------------------------------
    // Shift engine
    // ----------------------------------------

    // Load on start, shift on rising edges, capture at the end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shifter <= DATA_RESET;
            rx_buf <= DATA_RESET;
            bit_cnt <= 5'd0;
        end else if (!mode.enable) begin
            // disable wipes receive data and shifter
            shifter <= DATA_RESET;
            rx_buf <= DATA_RESET;
            bit_cnt <= 5'd0;
        end else if (start) begin
            // Receive-only keeps old contents; only sampled bits matter
            if (mode.trmd) shifter <= mode.ccl ? wb_dat_i[15:0] : {shifter[15:8], wb_dat_i[7:0]};
            bit_cnt <= 5'd0;
        end else if (rise) begin
            shifter <= next_shift;
            bit_cnt <= bit_cnt + 5'd1;
            if (done) rx_buf <= next_shift;
        end
    end

    // ----------------------------------------
    // Pins and completion flag
    // ----------------------------------------

    // Data out follows the falling edge; first bit appears at start
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_out_pin <= 1'b0;
        end else if (!mode.trmd || !mode.enable) begin
            serial_out_pin <= 1'b0;
        end else if (start) begin
            serial_out_pin <= mode.dir ? wb_dat_i[0] : (mode.ccl ? wb_dat_i[15] : wb_dat_i[7]);
        end else if (fall) begin
            serial_out_pin <= out_bit;
        end
    end

    // Master drives the clock; idle level is high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_clock_pin_o <= 1'b1;
            serial_clock_pin_oe <= 1'b0;
        end else begin
            serial_clock_pin_o <= sck_int;
            serial_clock_pin_oe <= !slave_mode;
        end
    end

    // Set beats clear so a finish in the clearing cycle is kept
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            completion_interrupt <= 1'b0;
        end else if (done) begin
            completion_interrupt <= 1'b1;
        end else if (rd_rx || wr_tx || (access && wb_we_i && wb_adr_i == OFF_MODE)) begin
            // cleared by a receive read or transmit write at the active width, or by any mode write
            completion_interrupt <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_start_sets_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start |=> mode.status) else $error("status not set after start");
    a_mirror_no_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && !wb_we_i && wb_adr_i == OFF_MIRROR_WORD && !mode.status) |=> !mode.status)
        else $error("mirror read started a transfer");
    a_init_no_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && wb_we_i && wb_adr_i == OFF_INIT_WORD && !mode.status) |=> !mode.status)
        else $error("initial buffer write started a transfer");
    a_shift_no_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && wb_adr_i == OFF_SHIFT_BYTE && !mode.status) |=> !mode.status)
        else $error("shift view read started a transfer");
    a_disable_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !mode.enable |=> (rx_buf == DATA_RESET && shifter == DATA_RESET && !mode.status))
        else $error("disable did not clear receive state");
    a_rxonly_out_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!$past(mode.trmd) && mode.status) |-> !serial_out_pin) else $error("output not low in receive-only");
    a_done_irq_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (done && mode.enable) |=> (completion_interrupt && !mode.status)) else $error("completion not signalled");
    a_irq_clear_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_rx && !done) |=> !completion_interrupt) else $error("interrupt not cleared by read");
    a_byte_alias: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (access && !wb_we_i && wb_adr_i == OFF_RX_BYTE && byte_ok) |=> wb_dat_o[7:0] == $past(rx_buf[7:0]))
        else $error("byte view does not alias word");
    a_bit_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mode.status |-> bit_cnt < last_bit) else $error("bit count overran length");
endmodule

// *** src/csi_pkg.sv ***
// Package: register map, field layout and timing constants of the clocked serial buffer block
package csi_pkg;

    // ----------------------------------------
    // Register byte offsets (word aligned)
    // ----------------------------------------
    localparam logic [7:0] OFF_MODE = 8'h00; // Serial mode register
    localparam logic [7:0] OFF_CLOCK = 8'h04; // Clock source control
    localparam logic [7:0] OFF_RX_WORD = 8'h08; // rx_buffer_word
    localparam logic [7:0] OFF_RX_BYTE = 8'h0c; // rx_buffer_byte
    localparam logic [7:0] OFF_MIRROR_WORD = 8'h10; // rx_mirror_word
    localparam logic [7:0] OFF_MIRROR_BYTE = 8'h14; // rx_mirror_byte
    localparam logic [7:0] OFF_TX_WORD = 8'h18; // tx_buffer_word
    localparam logic [7:0] OFF_TX_BYTE = 8'h1c; // tx_buffer_byte
    localparam logic [7:0] OFF_INIT_WORD = 8'h20; // initial_tx_word
    localparam logic [7:0] OFF_INIT_BYTE = 8'h24; // initial_tx_byte
    localparam logic [7:0] OFF_SHIFT_WORD = 8'h28; // shift_view_word
    localparam logic [7:0] OFF_SHIFT_BYTE = 8'h2c; // shift_view_byte

    // ----------------------------------------
    // Byte-lane patterns for sized access
    // ----------------------------------------
    localparam logic [3:0] SEL_WORD16 = 4'h3; // Whole 16-bit access
    localparam logic [3:0] SEL_BYTE0 = 4'h1; // Low byte lane

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // ----------------------------------------
    // Transfer lengths and timing
    // ----------------------------------------
    localparam logic [4:0] BITS_SHORT = 5'd8; // Data length bit = 0
    localparam logic [4:0] BITS_LONG = 5'd16; // Data length bit = 1
    localparam int CLK_HZ = 40000000; // ref_clk rate
    // Master serial clock half period; it must outlast the output register plus the
    // two data-in synchroniser flops, or the sampling edge sees the previous bit
    localparam int SCK_HALF_NS = 100;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS * (CLK_HZ / 1000000) + 999) / 1000;

    // Mode register layout, bit 7 down to bit 0
    typedef struct packed {
        logic enable; // interface_enable_bit
        logic trmd; // transfer_mode_bit: 1 = transmit/receive
        logic ccl; // data_length_bit: 1 = 16 bits
        logic dir; // 1 = LSB first
        logic delay; // Interrupt delay select, stored only
        logic auto_sel; // repeat_select_bit, stored only
        logic spare; // Reads zero
        logic status; // transfer_status_flag, read-only
    } mode_s;

endpackage

// *** sim/serial_peer.sv ***
// Serial peer model: far-side shifter that can also supply the serial clock
`timescale 1ns/1ps
module serial_peer (
    input wire logic sck_line,
    input wire logic sdo,
    input wire logic load,
    input wire logic go,
    input wire logic [4:0] nbits,
    input wire logic [15:0] tx_word,
    output logic sck_drive,
    output logic sdi,
    output logic [15:0] rx_word
);
    logic [15:0] out_sh; // Pending outgoing bits
    int cnt; // Rising edges seen this frame
    initial begin
        sck_drive = 1'b1;
        sdi = 1'b0;
        rx_word = 16'h0000;
        out_sh = 16'h0000;
        cnt = 0;
    end
    // Arm a new frame
    always @(posedge load) begin
        out_sh = tx_word;
        cnt = 0;
    end
    // Slave-mode clock: idles high, stands still outside frames
    always @(posedge go) begin
        repeat (nbits) begin
            #100 sck_drive = 1'b0;
            #100 sck_drive = 1'b1;
        end
    end
    // MSB first, launched on the falling edge
    always @(negedge sck_line) begin
        sdi = out_sh[nbits - 5'd1];
        out_sh = out_sh << 1;
    end
    // Capture on rising edge; 40 ns after the frame's last one the line no longer holds its value
    // Hold lasts past one system clock, since the block sees the edge up to a period late
    always @(posedge sck_line) begin
        rx_word = {rx_word[14:0], sdo};
        cnt++;
        if (cnt == int'(nbits)) begin
            #40 sdi = ~sdi;
        end
    end
endmodule

// *** sim/tb.sv ***
// Testbench: Wishbone stimulus, serial peer and queued result checks
`timescale 1ns/1ps
module tb;
    import csi_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, sck_o, sck_oe, serial_out_pin, completion_interrupt;
    logic sck_drive, sdi, load = 1'b0, go = 1'b0, so_low = 1'b0;
    logic [4:0] nbits = 5'd8;
    logic [15:0] peer_tx = 16'h0, peer_rx, a, b, w;
    logic [31:0] exp_q[$];
    int n_mismatch = 0, total_checks = 0, cycles = 0;
    // Wire level: whoever has the enable drives the clock line
    wire logic sck_line = sck_oe ? sck_o : sck_drive;

    always #12.5 ref_clk = ~ref_clk;

    csi_buffer dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_clock_pin_i(sck_line),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe), .serial_out_pin(serial_out_pin),
        .serial_in_pin(sdi), .completion_interrupt(completion_interrupt));
    serial_peer peer (.sck_line(sck_line), .sdo(serial_out_pin), .load(load), .go(go),
        .nbits(nbits), .tx_word(peer_tx), .sck_drive(sck_drive), .sdi(sdi), .rx_word(peer_rx));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= d;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus(1'b0, adr, sel, 32'h0);
    endtask
    task automatic arm(input logic [15:0] tx);
        peer_tx <= tx;
        @(posedge ref_clk) load <= 1'b1;
        @(posedge ref_clk) load <= 1'b0;
    endtask
    // Bounded wait for completion; receive-only keeps the data line low
    task automatic wait_irq;
        int n;
        n = 0;
        while (completion_interrupt !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            if (so_low) check(serial_out_pin, 0);
            n++;
        end
        // Let the far side take the last bit before anyone looks at it
        @(posedge ref_clk);
        check(completion_interrupt, 1);
    endtask

    // Read results come back in request order
    always @(posedge ref_clk) begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
            check(wb_dat_o, exp_q.pop_front());
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        void'($urandom(99));
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset state, unmapped place
        rd(OFF_MODE, SEL_BYTE0, 32'h0);
        rd(OFF_TX_WORD, SEL_WORD16, 32'h0);
        rd(8'h30, SEL_BYTE0, 32'h0);
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'hc0);
        // Back-to-back 8-bit exchanges; each write after the first finds the last completion still raised
        repeat (3) begin
            a = 16'($urandom() & 32'hff);
            b = 16'($urandom() & 32'hff);
            arm(b);
            bus(1'b1, OFF_TX_BYTE, SEL_BYTE0, {16'h0, a});
            check(completion_interrupt, 0);
            rd(OFF_MODE, SEL_BYTE0, 32'hc1);
            wait_irq();
            check(peer_rx[7:0], a[7:0]);
            rd(OFF_SHIFT_BYTE, SEL_BYTE0, {16'h0, b});
            rd(OFF_MIRROR_BYTE, SEL_BYTE0, {16'h0, b});
            rd(OFF_MODE, SEL_BYTE0, 32'hc0);
        end
        rd(OFF_RX_BYTE, SEL_BYTE0, {16'h0, b});
        check(completion_interrupt, 0);
        // LSB first, 8 bits: the peer shifts MSB first, so each side sees the other reversed
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'hd0);
        a = 16'($urandom() & 32'hff);
        b = 16'($urandom() & 32'hff);
        arm(b);
        bus(1'b1, OFF_TX_BYTE, SEL_BYTE0, {16'h0, a});
        wait_irq();
        for (int i = 0; i < 8; i++) w[i] = a[7 - i];
        check(peer_rx[7:0], w[7:0]);
        for (int i = 0; i < 8; i++) w[i] = b[7 - i];
        rd(OFF_RX_BYTE, SEL_BYTE0, {24'h0, w[7:0]});
        // 16-bit exchange, read-only and alias views
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'he0);
        nbits <= 5'd16;
        w = 16'($urandom());
        b = 16'($urandom());
        arm(b);
        bus(1'b1, OFF_TX_WORD, SEL_WORD16, {16'h0, w});
        wait_irq();
        check(peer_rx, w);
        rd(OFF_SHIFT_WORD, SEL_WORD16, {16'h0, b});
        rd(OFF_TX_WORD, SEL_WORD16, {16'h0, w});
        bus(1'b1, OFF_RX_WORD, SEL_WORD16, 32'h1234);
        rd(OFF_MIRROR_WORD, SEL_WORD16, {16'h0, b});
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'he0);
        check(completion_interrupt, 0);
        rd(OFF_RX_WORD, SEL_WORD16, {16'h0, b});
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'hc0);
        check(completion_interrupt, 0);
        rd(OFF_RX_BYTE, SEL_BYTE0, {24'h0, b[7:0]});
        rd(OFF_TX_BYTE, SEL_BYTE0, {24'h0, w[7:0]});
        // Initial buffer stores only; narrow lanes refused
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'he0);
        a = 16'($urandom());
        // initial buffer write does not start a transfer
        bus(1'b1, OFF_INIT_WORD, SEL_WORD16, {16'h0, a});
        bus(1'b1, OFF_INIT_WORD, SEL_BYTE0, 32'h5a);
        rd(OFF_MODE, SEL_BYTE0, 32'he0);
        rd(OFF_INIT_WORD, SEL_WORD16, {16'h0, a});
        // Receive-only: buffer read starts, mirror read does not
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'h80);
        nbits <= 5'd8;
        a = 16'($urandom() & 32'hff);
        arm(a);
        so_low <= 1'b1;
        rd(OFF_RX_BYTE, SEL_BYTE0, {24'h0, b[7:0]});
        rd(OFF_MODE, SEL_BYTE0, 32'h81);
        wait_irq();
        so_low <= 1'b0;
        rd(OFF_MIRROR_BYTE, SEL_BYTE0, {16'h0, a});
        rd(OFF_MODE, SEL_BYTE0, 32'h80);
        // Slave mode with the peer clocking at 200 ns
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'h00);
        bus(1'b1, OFF_CLOCK, SEL_BYTE0, 32'h01);
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'hc0);
        a = 16'($urandom() & 32'hff);
        b = 16'($urandom() & 32'hff);
        arm(b);
        bus(1'b1, OFF_TX_BYTE, SEL_BYTE0, {16'h0, a});
        check(sck_oe, 0);
        @(posedge ref_clk) go <= 1'b1;
        @(posedge ref_clk) go <= 1'b0;
        wait_irq();
        check(peer_rx[7:0], a[7:0]);
        rd(OFF_RX_BYTE, SEL_BYTE0, {16'h0, b});
        // Disable in mid-transfer wipes status and data
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'h00);
        bus(1'b1, OFF_CLOCK, SEL_BYTE0, 32'h00);
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'hc0);
        arm(16'h00a5);
        bus(1'b1, OFF_TX_BYTE, SEL_BYTE0, 32'h3c);
        repeat (6) @(posedge ref_clk);
        bus(1'b1, OFF_MODE, SEL_BYTE0, 32'h40);
        rd(OFF_MODE, SEL_BYTE0, 32'h40);
        rd(OFF_RX_BYTE, SEL_BYTE0, 32'h0);
        rd(OFF_SHIFT_BYTE, SEL_BYTE0, 32'h0);
        check(completion_interrupt, 0);
        check(sck_o, 1);
        check(sck_oe, 1);
        repeat (3) @(posedge ref_clk);
        test_done();
    end
endmodule
